/* bsr_defs.svh */
/*
  constants for the boot strap and reset control block.
  assumes a 20 MHz clock; included by the package and the design.
*/
`ifndef BSR_DEFS_SVH
`define BSR_DEFS_SVH
`define BSR_CLK_HZ          20000000
`define BSR_POR_HOLD_US     100
`define BSR_POR_HOLD_CYC    ((`BSR_POR_HOLD_US * (`BSR_CLK_HZ / 1000000)))
`define BSR_CNT_W           12
`define BSR_MODE_FUSE       2'h0
`define BSR_MODE_SERIAL     2'h1
`define BSR_MODE_INTERNAL   2'h2
`define BSR_MODE_RESERVED   2'h3
`define BSR_CFG_RESET       16'h0000
`endif

/* bsr_pkg.sv */
/*
  types for the boot strap and reset control block.
  assumes bsr_defs.svh is on the include path.
*/
`include "bsr_defs.svh"
package bsr_pkg;
  typedef enum logic [1:0] {
    BSR_BOOT_FUSE     = 2'b00,
    BSR_BOOT_SERIAL   = 2'b01,
    BSR_BOOT_INTERNAL = 2'b10,
    BSR_BOOT_RESERVED = 2'b11
  } bsr_boot_mode_t;

  typedef struct packed {
    bsr_boot_mode_t mode;
    logic           override_en;
    logic [15:0]    override_cfg;
    logic           reserved_code;
  } bsr_boot_cfg_t;
endpackage

/* bsr_boot_strap_reset_control.sv */
/*
  boot strap latch and reset sequencer: syncs reset requests, drives the
  open-drain power-on reset, latches boot straps and override pins.
  assumes straps and reset pins are asynchronous to clk; clk is free-running.
*/
// Functional notes
// - straps 00 fuse boot, 01 serial downloader, 10 internal boot, 11 reserved
// - override pins only alter boot configuration when straps read 10
// - internal boot latches eight rx and eight tx pins into 16-bit word
// - power-on reset is active-low open-drain, holds processor, visible to baseboard
// - low power-cycle request restarts the power sequence; undriven reads inactive
// - system reset held while system reset input is low; button recommended
// - undriven strap and override pins read zero through weak pull-downs
`include "bsr_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module bsr_boot_strap_reset_control #(
  parameter int unsigned POR_HOLD_CYC = `BSR_POR_HOLD_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   boot_select_bit0,
  input  wire logic                   boot_select_bit1,
  input  wire logic [7:0]             audio_port_rx_override_pins,
  input  wire logic [7:0]             audio_port_tx_override_pins,
  input  wire logic                   power_cycle_request_n,
  input  wire logic                   system_reset_in_n,
  input  wire logic                   por_pin_in,
  output logic                        por_out,
  output logic                        por_oe,
  output logic                        processor_reset_n,
  output bsr_pkg::bsr_boot_cfg_t      boot_cfg,
  output logic                        boot_cfg_valid
);
  import bsr_pkg::*;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // pin pull resistors are board-level; here undriven pins arrive as
  // the resolved wire level: high for reset requests, low for straps
  localparam int NSYNC = 21;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  wire  [NSYNC-1:0] raw_in = {por_pin_in, system_reset_in_n, power_cycle_request_n,
                              audio_port_tx_override_pins, audio_port_rx_override_pins,
                              boot_select_bit1, boot_select_bit0};

  // each sync stage resets to the idle level of its pin, so no false request
  // or strap change is seen in the first cycles after reset
  localparam logic [NSYNC-1:0] SYNC_RST = {3'h7, 18'h00000};

  // two stages per pin; only the second stage is read, so a metastable
  // first stage never reaches the sequencer or the strap latch
  generate
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          sync1_reg[i] <= SYNC_RST[i];
          sync2_reg[i] <= SYNC_RST[i];
        end else begin
          sync1_reg[i] <= raw_in[i];
          sync2_reg[i] <= sync1_reg[i];
        end
      end
    end
  endgenerate

  logic [1:0]  strap_s;
  logic [15:0] ovr_s;
  logic        pwr_req_n_s;
  logic        sys_rst_n_s;
  logic        por_pin_s;
  assign strap_s     = sync2_reg[1:0];
  assign ovr_s       = {sync2_reg[17:10], sync2_reg[9:2]};
  assign pwr_req_n_s = sync2_reg[18];
  assign sys_rst_n_s = sync2_reg[19];
  assign por_pin_s   = sync2_reg[20];

  // ------------------------------------------------------------
  // power-on reset sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HOLD    = 2'b00,
    ST_RUN     = 2'b01,
    ST_SYSRST  = 2'b10
  } bsr_seq_state_t;

  bsr_seq_state_t   state_reg;
  logic [31:0]      hold_cnt_reg;
  logic             hold_done;
  assign hold_done = (hold_cnt_reg >= POR_HOLD_CYC - 1);

  // state: hold -> run after a full count, run -> hold on a power-cycle
  // request, run -> system reset while the reset input is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_HOLD;
    end else begin
      unique case (state_reg)
        ST_HOLD: begin
          // a request held low keeps the count at zero, so no release here
          if (pwr_req_n_s && hold_done) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!pwr_req_n_s) begin
            state_reg <= ST_HOLD;
          end else if (!sys_rst_n_s) begin
            state_reg <= ST_SYSRST;
          end
        end
        ST_SYSRST: begin
          // stays in reset for as long as the input is held low
          if (!pwr_req_n_s) begin
            state_reg <= ST_HOLD;
          end else if (sys_rst_n_s) begin
            state_reg <= ST_HOLD;
          end
        end
        default: begin
          state_reg <= ST_HOLD;
        end
      endcase
    end
  end

  // hold counter: counts only in hold, restarts while a power-cycle
  // request stays low, so the hold time is measured from its release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_cnt_reg <= 32'h00000000;
    end else if (state_reg != ST_HOLD) begin
      hold_cnt_reg <= 32'h00000000;
    end else if (!pwr_req_n_s) begin
      hold_cnt_reg <= 32'h00000000;
    end else if (hold_done) begin
      hold_cnt_reg <= 32'h00000000;
    end else begin
      hold_cnt_reg <= hold_cnt_reg + 32'h00000001;
    end
  end

  // ------------------------------------------------------------
  // power-on reset wire
  // ------------------------------------------------------------
  // open-drain: only ever drive low, release by tri-stating
  // the level stays low in every state; only the enable moves, so the
  // board pull-up alone decides the released level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      por_out <= 1'b0;
      por_oe  <= 1'b1;
    end else begin
      por_out <= 1'b0;
      por_oe  <= (state_reg != ST_RUN);
    end
  end

  // ------------------------------------------------------------
  // processor reset
  // ------------------------------------------------------------
  // processor follows the wire, so a baseboard holding the line low also holds it
  // limitation: the sensed wire lags por_oe by the two sync stages, which
  // only delays the release and never shortens the hold
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      processor_reset_n <= 1'b0;
    end else begin
      processor_reset_n <= (state_reg == ST_RUN) && por_oe == 1'b0 && por_pin_s;
    end
  end

  // ------------------------------------------------------------
  // boot strap latch
  // ------------------------------------------------------------
  logic release_edge;
  assign release_edge = (state_reg == ST_HOLD) && hold_done && pwr_req_n_s;

  // the word loads only on the release edge; straps moving later are ignored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_cfg <= '{mode: BSR_BOOT_FUSE, override_en: 1'b0,
                    override_cfg: `BSR_CFG_RESET, reserved_code: 1'b0};
    end else if (release_edge) begin
      // a sample taken at the release edge stays frozen until the next release edge
      boot_cfg.mode          <= bsr_boot_mode_t'(strap_s);
      boot_cfg.reserved_code <= (strap_s == `BSR_MODE_RESERVED);
      boot_cfg.override_en   <= (strap_s == `BSR_MODE_INTERNAL);
      // override pins are masked outside internal boot, so stray levels never leak
      boot_cfg.override_cfg  <= (strap_s == `BSR_MODE_INTERNAL) ? ovr_s : `BSR_CFG_RESET;
    end
  end

  // valid falls one cycle after hold is entered and stays low until release, so no half-loaded word is trusted;
  // it rises on the same edge as the load
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_cfg_valid <= 1'b0;
    end else if (state_reg == ST_HOLD) begin
      boot_cfg_valid <= release_edge;
    end else begin
      boot_cfg_valid <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* bsr_monitor.sv */
/* checker for the boot strap and reset block.
   bound to the design top; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module bsr_monitor
  import bsr_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic                   power_cycle_request_n,
  input wire logic                   system_reset_in_n,
  input wire logic                   por_pin_in,
  input wire logic                   por_out,
  input wire logic                   por_oe,
  input wire logic                   processor_reset_n,
  input wire bsr_pkg::bsr_boot_cfg_t boot_cfg,
  input wire logic                   boot_cfg_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence pwr_req_s; !power_cycle_request_n [*3]; endsequence
  sequence sys_req_s; boot_cfg_valid && $fell(system_reset_in_n); endsequence
  por_drive_low_a: assert property (por_out == 1'b0) else $error("por level");
  cpu_held_a: assert property (por_oe && $past(por_oe) |-> !processor_reset_n) else $error("cpu early");
  pin_sense_a: assert property ($rose(processor_reset_n) |-> $past(por_pin_in)) else $error("wire low");
  zero_override_a: assert property (boot_cfg_valid && boot_cfg.mode != BSR_BOOT_INTERNAL
    |-> boot_cfg.override_cfg == 16'h0000) else $error("override leak");
  mode_flags_a: assert property (boot_cfg_valid |-> boot_cfg.reserved_code == (boot_cfg.mode == BSR_BOOT_RESERVED)
    && boot_cfg.override_en == (boot_cfg.mode == BSR_BOOT_INTERNAL)) else $error("mode flags");
  cfg_hold_a: assert property (boot_cfg_valid && $past(boot_cfg_valid) |-> $stable(boot_cfg)) else $error("cfg moved");
  sys_reset_a: assert property (sys_req_s |-> ##[1:4] por_oe) else $error("no sys reset");
  pwr_cycle_a: assert property (pwr_req_s |-> ##[0:3] !boot_cfg_valid) else $error("no power cycle");
endmodule
bind bsr_boot_strap_reset_control bsr_monitor bsr_monitor_i (.*);
`default_nettype wire

/* bsr_board.sv */
/* baseboard side of the power-on reset wire.
   assumes the design's por_oe; no one else pulls the wire. */
`timescale 1ns/10ps
`default_nettype none
module bsr_board (
  input wire logic por_oe,
  output logic     por_pin_in
);
  // pulled up on the board, so a released wire reads high
  assign por_pin_in = !por_oe;
endmodule
`default_nettype wire

/* test_boot_strap_reset_control.sv */
/* bench for the boot strap and reset block.
   assumes package, design, board model and checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module test_boot_strap_reset_control;
  import bsr_pkg::*;
  logic          clk = 0, rst_b = 0, b0 = 0, b1 = 0, pwr_n = 1, sys_n = 1;
  logic [7:0]    rx = 0, tx = 0;
  logic          pin, por_out, por_oe, cpu_n, valid;
  bsr_boot_cfg_t cfg;
  int            fails = 0, checks_done = 0, cyc = 0;
  initial forever #25 clk = ~clk;
  bsr_boot_strap_reset_control #(.POR_HOLD_CYC(8)) bsr_boot_strap_reset_control_i (.clk(clk), .rst_b(rst_b),
    .boot_select_bit0(b0), .boot_select_bit1(b1), .audio_port_rx_override_pins(rx),
    .audio_port_tx_override_pins(tx), .power_cycle_request_n(pwr_n), .system_reset_in_n(sys_n),
    .por_pin_in(pin), .por_out(por_out), .por_oe(por_oe), .processor_reset_n(cpu_n),
    .boot_cfg(cfg), .boot_cfg_valid(valid));
  bsr_board bsr_board_i (.por_oe(por_oe), .por_pin_in(pin));
  function automatic logic [19:0] want(logic [1:0] m, logic [7:0] r, t);
    return {m, m == 2'h2, m == 2'h2 ? {t, r} : 16'h0000, m == 2'h3};
  endfunction
  task chk(logic [19:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task close_out;
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // sample on falling edges, clear of the drive edge
  task up(int n);
    repeat (n) if (cpu_n !== 1'b1) @(negedge clk);
  endtask
  task boot(logic [1:0] m, logic [7:0] r, t);
    @(posedge clk);
    rst_b <= 0;
    {b1, b0} <= m;
    rx <= r;
    tx <= t;
    repeat (2) @(posedge clk);
    rst_b <= 1;
    up(40);
    chk(cfg, want(m, r, t));
    chk(20'({valid, cpu_n, por_oe}), 20'h6);
    @(posedge clk);
    {b1, b0} <= ~m;
    rx <= ~r;
    repeat (6) @(negedge clk);
    chk(cfg, want(m, r, t));
  endtask
  task sys_reset;
    @(posedge clk);
    sys_n <= 0;
    {b1, b0} <= 2'h1;
    repeat (6) @(negedge clk);
    chk(20'({valid, cpu_n, por_oe}), 20'h5);
    @(posedge clk);
    sys_n <= 1;
    up(40);
    chk(cfg, want(2'h1, rx, tx));
  endtask
  task pwr_cycle;
    @(posedge clk);
    pwr_n <= 0;
    {b1, b0} <= 2'h2;
    rx <= 8'h81;
    tx <= 8'h7E;
    repeat (20) @(negedge clk);
    chk(20'({valid, cpu_n, por_oe}), 20'h1);
    @(posedge clk);
    pwr_n <= 1;
    up(40);
    chk(cfg, want(2'h2, 8'h81, 8'h7E));
  endtask
  initial begin
    for (int m = 0; m < 4; m++) boot(2'(m), 8'hA5, 8'h3C);
    sys_reset();
    pwr_cycle();
    close_out();
  end
  // the tasks need some 150 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      close_out();
    end
  end
endmodule
`default_nettype wire
